// ---- hw/svcfg_pkg.sv ----
// Constants shared by the channel configuration register bank
package svcfg_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int DEB_BASE_TIME_NS = 100;
    localparam int DEB_MAX_CODE = 10;
    localparam int DEB_CNT_W = 14;
    localparam int NUM_REGS = 6;
    localparam int IDX_DEB = 0;
    localparam int IDX_CUT = 1;
    localparam int IDX_THR0 = 2;
    localparam logic [7:0] OFS_FAST_DEBOUNCE = 8'h54;
    localparam logic [7:0] OFS_SLOW_CUTOFF = 8'h55;
    localparam logic [7:0] OFS_FAST_UNDER = 8'h60;
    localparam logic [7:0] OFS_FAST_OVER = 8'h61;
    localparam logic [7:0] OFS_SLOW_UNDER = 8'h62;
    localparam logic [7:0] OFS_SLOW_OVER = 8'h63;
    localparam logic [7:0] RST_FAST_DEBOUNCE = 8'h00;
    localparam logic [7:0] RST_SLOW_CUTOFF = 8'h14;
    localparam logic [7:0] RST_UNDER_LIMIT = 8'h00;
    localparam logic [7:0] RST_OVER_LIMIT = 8'hff;
    localparam logic [7:0] CUTOFF_WMASK = 8'h1f;
    localparam logic [7:0] FULL_WMASK = 8'hff;
    localparam logic [7:0] REG_OFS [NUM_REGS] = '{OFS_FAST_DEBOUNCE, OFS_SLOW_CUTOFF,
        OFS_FAST_UNDER, OFS_FAST_OVER, OFS_SLOW_UNDER, OFS_SLOW_OVER};
    localparam logic [7:0] REG_RST [NUM_REGS] = '{RST_FAST_DEBOUNCE, RST_SLOW_CUTOFF,
        RST_UNDER_LIMIT, RST_OVER_LIMIT, RST_UNDER_LIMIT, RST_OVER_LIMIT};
    localparam logic [7:0] REG_WMASK [NUM_REGS] = '{FULL_WMASK, CUTOFF_WMASK,
        FULL_WMASK, FULL_WMASK, FULL_WMASK, FULL_WMASK};
    localparam int UNDER_SETTLE_LSB = 0;
    localparam int OVER_SETTLE_LSB = 4;
    localparam int ROUTE_LSB = 3;
    localparam int CUTOFF_LSB = 0;
    localparam logic [2:0] CUT_250HZ = 3'h2;
    localparam logic [2:0] CUT_500HZ = 3'h3;
    localparam logic [2:0] CUT_1KHZ = 3'h4;
    localparam logic [2:0] CUT_2KHZ = 3'h5;
    localparam logic [2:0] CUT_4KHZ = 3'h6;
    localparam logic [12:0] HZ_250 = 13'h00fa;
    localparam logic [12:0] HZ_500 = 13'h01f4;
    localparam logic [12:0] HZ_1K = 13'h03e8;
    localparam logic [12:0] HZ_2K = 13'h07d0;
    localparam logic [12:0] HZ_4K = 13'h0fa0;
    localparam logic [12:0] MV_BASE_1X = 13'h00c8;
    localparam logic [12:0] MV_STEP_1X = 13'h0005;
    localparam logic [12:0] MV_BASE_4X = 13'h0320;
    localparam logic [12:0] MV_STEP_4X = 13'h0014;
endpackage

// ---- hw/svcfg_settle.sv ----
// Comparator settle filter with doubling interval code
`timescale 1ns/1ps
module svcfg_settle #(
    parameter int BASE_NS = svcfg_pkg::DEB_BASE_TIME_NS
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic raw_i,
    input wire logic [3:0] code_i,
    output logic fault_o
);
    import svcfg_pkg::*;

    function automatic logic [DEB_CNT_W-1:0] settle_cycles(input logic [3:0] code);
        int k;
        int c;
        k = (int'(code) > DEB_MAX_CODE) ? DEB_MAX_CODE : int'(code);
        c = ((BASE_NS << k) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[DEB_CNT_W-1:0];
    endfunction

    logic fault_reg;
    logic fault_next;
    logic [DEB_CNT_W-1:0] cnt_reg;
    logic [DEB_CNT_W-1:0] cnt_next;
    wire logic [DEB_CNT_W-1:0] lim = settle_cycles(code_i);
    wire logic differs = raw_i != fault_reg;
    wire logic done = differs && (cnt_reg >= lim - DEB_CNT_W'(1));

    // Follow the comparator only once it has held its new level for the whole interval
    assign fault_next = done ? raw_i : fault_reg;
    // A bounce back before the interval ends restarts the count
    assign cnt_next = (!differs || done) ? '0 : cnt_reg + DEB_CNT_W'(1);
    assign fault_o = fault_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fault_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            fault_reg <= fault_next;
            cnt_reg <= cnt_next;
        end
    end

    property p_settle_full;
        @(posedge clk_i) disable iff (srst_i)
        // Sampled reset keeps the release edge out, where reset itself moved the fault
        !srst_i && $changed(fault_reg) |-> $past(cnt_reg) == $past(lim) - DEB_CNT_W'(1);
    endproperty
    a_settle_full: assert property (p_settle_full) else $error("fault moved early");

    property p_settle_restart;
        @(posedge clk_i) disable iff (srst_i)
        (raw_i == fault_reg) |=> cnt_reg == '0;
    endproperty
    a_settle_restart: assert property (p_settle_restart) else $error("count not restarted");

    property p_settle_saturate;
        @(posedge clk_i) disable iff (srst_i)
        (int'(code_i) > DEB_MAX_CODE) |-> lim == settle_cycles(4'(DEB_MAX_CODE));
    endproperty
    a_settle_saturate: assert property (p_settle_saturate) else $error("no saturation");
endmodule

// ---- hw/svcfg_regs.sv ----
// Channel 4 settle and cutoff setup, channel 5 window limits
`timescale 1ns/1ps
// Overview of operation
// - Over-limit settle code in bits 7:4 gives 0.1 us doubled per step, capped at 102.4 us.
// - Under-limit settle code in bits 3:0 decodes the same way.
// - A fast-path fault only follows the comparator after it held steady for the interval.
// - Bits 4:3 of the cutoff register route fast faults to reset: none, under, over, both.
// - Bits 2:0 pick the slow cutoff 250 Hz to 4 kHz; codes 0, 1 and 7 are invalid.
// - The slow filter is set so the whole path has its 3 dB point at the chosen cutoff.
// - Each 8-bit limit means 0.2 V + 5 mV steps at 1x, or 0.8 V + 20 mV steps at 4x.
// - Fast and slow paths each have their own under and over limits and are compared alone.
// - Reset loads under limits with 0x00 and over limits with 0xFF.
// - The cutoff register resets to 0x14 and its top three bits read zero.
module svcfg_regs #(
    parameter int DEB_BASE_NS = svcfg_pkg::DEB_BASE_TIME_NS
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic range_scaling_select_i,
    input wire logic ch4_fast_under_raw_i,
    input wire logic ch4_fast_over_raw_i,
    output logic fast_path_under_fault_o,
    output logic fast_path_over_fault_o,
    output logic fast_fault_to_reset_o,
    output logic [2:0] slow_path_cutoff_o,
    output logic [12:0] slow_path_cutoff_hz_o,
    output logic cutoff_cfg_err_o,
    input wire logic [7:0] ch5_fast_sample_i,
    input wire logic [7:0] ch5_slow_sample_i,
    output logic ch5_fast_under_o,
    output logic ch5_fast_over_o,
    output logic ch5_slow_under_o,
    output logic ch5_slow_over_o,
    output logic [12:0] ch5_fast_under_mv_o,
    output logic [12:0] ch5_fast_over_mv_o,
    output logic [12:0] ch5_slow_under_mv_o,
    output logic [12:0] ch5_slow_over_mv_o
);
    import svcfg_pkg::*;

    logic [7:0] cfg_reg [NUM_REGS];
    logic [NUM_REGS-1:0] hit;
    logic [7:0] rd_mux;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic [2:0] cut_applied_reg;
    logic [12:0] cut_hz_reg;
    logic [12:0] cut_hz_next;
    logic cut_err_reg;
    logic route_reg;
    logic [1:0] raw_flt;
    logic [1:0] fast_flt;
    logic [3:0] cmp_reg;
    logic [12:0] mv_reg [4];

    // Register file: one entry per mapped offset
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            assign hit[gi] = reg_addr_i == REG_OFS[gi];
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    cfg_reg[gi] <= REG_RST[gi];
                end else if (reg_wr_i && hit[gi]) begin
                    cfg_reg[gi] <= reg_wdata_i & REG_WMASK[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_mux = cfg_reg[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= reg_rd_i ? rd_mux : rdata_reg;
            rvalid_reg <= reg_rd_i;
        end
    end
    assign reg_rdata_o = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;

    // Fast-path settle filters, index 0 under and 1 over to match the route bits
    wire logic [1:0] route = cfg_reg[IDX_CUT][ROUTE_LSB +: 2];
    wire logic [3:0] settle_code [2];
    assign settle_code[0] = cfg_reg[IDX_DEB][UNDER_SETTLE_LSB +: 4];
    assign settle_code[1] = cfg_reg[IDX_DEB][OVER_SETTLE_LSB +: 4];
    assign raw_flt[0] = ch4_fast_under_raw_i;
    assign raw_flt[1] = ch4_fast_over_raw_i;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_settle
            svcfg_settle #(
                .BASE_NS(DEB_BASE_NS)
            ) u_settle (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .raw_i(raw_flt[gi]),
                .code_i(settle_code[gi]),
                .fault_o(fast_flt[gi])
            );
        end
    endgenerate
    assign fast_path_under_fault_o = fast_flt[0];
    assign fast_path_over_fault_o = fast_flt[1];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            route_reg <= 1'b0;
        end else begin
            route_reg <= |(route & fast_flt);
        end
    end
    assign fast_fault_to_reset_o = route_reg;

    // Cutoff select; a bad code never reaches the filter
    wire logic [2:0] cut_code = cfg_reg[IDX_CUT][CUTOFF_LSB +: 3];
    wire logic cut_valid = (cut_code >= CUT_250HZ) && (cut_code <= CUT_4KHZ);

    always_comb begin
        case (cut_applied_reg)
            CUT_250HZ: cut_hz_next = HZ_250;
            CUT_500HZ: cut_hz_next = HZ_500;
            CUT_2KHZ: cut_hz_next = HZ_2K;
            CUT_4KHZ: cut_hz_next = HZ_4K;
            default: cut_hz_next = HZ_1K;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cut_applied_reg <= CUT_1KHZ;
            cut_hz_reg <= HZ_1K;
            cut_err_reg <= 1'b0;
        end else begin
            cut_applied_reg <= cut_valid ? cut_code : cut_applied_reg;
            cut_hz_reg <= cut_hz_next;
            cut_err_reg <= !cut_valid;
        end
    end
    assign slow_path_cutoff_o = cut_applied_reg;
    assign slow_path_cutoff_hz_o = cut_hz_reg;
    assign cutoff_cfg_err_o = cut_err_reg;

    // Channel 5 limits: entries fast under, fast over, slow under, slow over
    generate
        for (gi = 0; gi < 4; gi++) begin : g_limit
            wire logic [7:0] thr = cfg_reg[IDX_THR0 + gi];
            wire logic [7:0] smp = (gi < 2) ? ch5_fast_sample_i : ch5_slow_sample_i;
            wire logic trip = (gi % 2 == 0) ? (smp < thr) : (smp > thr);
            wire logic [12:0] mv = range_scaling_select_i ?
                13'(MV_BASE_4X + MV_STEP_4X * 13'(thr)) :
                13'(MV_BASE_1X + MV_STEP_1X * 13'(thr));
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    cmp_reg[gi] <= 1'b0;
                    mv_reg[gi] <= 13'h0000;
                end else begin
                    cmp_reg[gi] <= trip;
                    mv_reg[gi] <= mv;
                end
            end
        end
    endgenerate
    assign ch5_fast_under_o = cmp_reg[0];
    assign ch5_fast_over_o = cmp_reg[1];
    assign ch5_slow_under_o = cmp_reg[2];
    assign ch5_slow_over_o = cmp_reg[3];
    assign ch5_fast_under_mv_o = mv_reg[0];
    assign ch5_fast_over_mv_o = mv_reg[1];
    assign ch5_slow_under_mv_o = mv_reg[2];
    assign ch5_slow_over_mv_o = mv_reg[3];

    property p_limit_reset;
        @(posedge clk_i) disable iff (srst_i)
        $fell(srst_i) |-> cfg_reg[2] == RST_UNDER_LIMIT && cfg_reg[3] == RST_OVER_LIMIT
            && cfg_reg[4] == RST_UNDER_LIMIT && cfg_reg[5] == RST_OVER_LIMIT;
    endproperty
    a_limit_reset: assert property (p_limit_reset) else $error("limit reset wrong");

    property p_cut_reset;
        @(posedge clk_i) disable iff (srst_i)
        $fell(srst_i) |-> cfg_reg[IDX_CUT] == RST_SLOW_CUTOFF && slow_path_cutoff_o == CUT_1KHZ;
    endproperty
    a_cut_reset: assert property (p_cut_reset) else $error("cutoff reset wrong");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (srst_i)
        (reg_rd_i && reg_addr_i == OFS_SLOW_CUTOFF) |=> reg_rvalid_o && reg_rdata_o[7:5] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_route;
        @(posedge clk_i) disable iff (srst_i)
        ##1 fast_fault_to_reset_o == (($past(route[0]) && $past(fast_flt[0]))
            || ($past(route[1]) && $past(fast_flt[1])));
    endproperty
    a_route: assert property (p_route) else $error("reset routing wrong");

    property p_cut_keep;
        @(posedge clk_i) disable iff (srst_i)
        !cut_valid |=> $stable(slow_path_cutoff_o) && cutoff_cfg_err_o;
    endproperty
    a_cut_keep: assert property (p_cut_keep) else $error("bad cutoff applied");

    property p_cut_apply;
        @(posedge clk_i) disable iff (srst_i)
        cut_valid |=> slow_path_cutoff_o == $past(cut_code)
            ##1 slow_path_cutoff_hz_o == (HZ_250 << ($past(cut_code, 2) - CUT_250HZ));
    endproperty
    a_cut_apply: assert property (p_cut_apply) else $error("cutoff not applied");

    property p_window_cmp;
        @(posedge clk_i) disable iff (srst_i)
        (ch5_slow_sample_i > cfg_reg[5]) |=> ch5_slow_over_o && !ch5_fast_over_o == 
            ($past(ch5_fast_sample_i) <= $past(cfg_reg[3]));
    endproperty
    a_window_cmp: assert property (p_window_cmp) else $error("window compare wrong");

    property p_scale_4x;
        @(posedge clk_i) disable iff (srst_i)
        // Sampled reset keeps out the release edge, where the mv register was just cleared
        !srst_i && range_scaling_select_i |=>
            ch5_fast_over_mv_o == 13'(MV_BASE_4X + MV_STEP_4X * 13'($past(cfg_reg[3])));
    endproperty
    a_scale_4x: assert property (p_scale_4x) else $error("4x scaling wrong");
endmodule

// ---- verification/svcfg_host.sv ----
// Host model that drives the parallel register port of the bank
`timescale 1ns/1ps
module svcfg_host (
    input wire logic clk_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    // Idle lines carry the inverse of the last value so stale data never looks right
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        ok = reg_rvalid_i;
        d = reg_rdata_i;
    endtask
endmodule

// ---- verification/svcfg_regs_tb.sv ----
// Self-checking bench for the channel configuration register bank
`timescale 1ns/1ps
module svcfg_regs_tb;
    import svcfg_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] lim;
        logic [7:0] smp;
        logic scl;
        logic flag;
    } svcfg_row_t;
    // Short base keeps the longest settle interval near a thousand cycles
    localparam int BASE_NS = 8;
    localparam svcfg_row_t ROWS [8] = '{
        '{8'h60, 8'h40, 8'h3f, 1'b0, 1'b1}, '{8'h60, 8'h40, 8'h40, 1'b1, 1'b0},
        '{8'h61, 8'h80, 8'h81, 1'b0, 1'b1}, '{8'h61, 8'h80, 8'h80, 1'b1, 1'b0},
        '{8'h62, 8'h00, 8'h00, 1'b0, 1'b0}, '{8'h62, 8'hff, 8'hfe, 1'b1, 1'b1},
        '{8'h63, 8'hfe, 8'hff, 1'b0, 1'b1}, '{8'h63, 8'h10, 8'h0f, 1'b1, 1'b0}};
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic scale = 1'b0;
    logic uv_raw = 1'b0;
    logic ov_raw = 1'b0;
    logic [7:0] fast_smp = 8'h80;
    logic [7:0] slow_smp = 8'h80;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, rvalid, ok, fu, fo, rst_req, err;
    logic [2:0] cut, last;
    logic [12:0] hz;
    logic [3:0] flag_v;
    logic [3:0][12:0] mv_v;
    int error_cnt = 0;
    int n_tests = 0;
    int n;
    svcfg_row_t r;

    svcfg_host i_host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
        .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    svcfg_regs #(.DEB_BASE_NS(BASE_NS)) i_dut (.clk_i(clk_i), .srst_i(srst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .range_scaling_select_i(scale),
        .ch4_fast_under_raw_i(uv_raw), .ch4_fast_over_raw_i(ov_raw),
        .fast_path_under_fault_o(fu), .fast_path_over_fault_o(fo),
        .fast_fault_to_reset_o(rst_req), .slow_path_cutoff_o(cut),
        .slow_path_cutoff_hz_o(hz), .cutoff_cfg_err_o(err),
        .ch5_fast_sample_i(fast_smp), .ch5_slow_sample_i(slow_smp),
        .ch5_fast_under_o(flag_v[0]), .ch5_fast_over_o(flag_v[1]),
        .ch5_slow_under_o(flag_v[2]), .ch5_slow_over_o(flag_v[3]),
        .ch5_fast_under_mv_o(mv_v[0]), .ch5_fast_over_mv_o(mv_v[1]),
        .ch5_slow_under_mv_o(mv_v[2]), .ch5_slow_over_mv_o(mv_v[3]));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk_val(input logic [12:0] got, input logic [12:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_val(13'(got), 13'(exp), what);
    endtask
    function automatic logic [12:0] exp_mv(input logic s, input logic [7:0] v);
        return s ? MV_BASE_4X + MV_STEP_4X * 13'(v) : MV_BASE_1X + MV_STEP_1X * 13'(v);
    endfunction
    // Counts edges until the chosen settled fault reaches the wanted level
    task automatic meas(input logic ov, input logic lvl);
        n = 0;
        while (n < 2000 && (ov ? fo : fu) !== lvl) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        srst_i <= 1'b1;
        uv_raw <= 1'b0;
        ov_raw <= 1'b0;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
    endtask
    task automatic chk_reset(input string name);
        #1;
        chk_val(13'(cut), 13'(CUT_1KHZ), "reset cutoff");
        chk_val(hz, HZ_1K, "reset cutoff hz");
        chk_bit(fu | fo | rst_req | err, 1'b0, "reset flags");
        i_host.wr(8'h56, 8'h5a);
        i_host.rd(8'h56, d, ok);
        chk_val(13'(d), 13'h0000, "unmapped read");
        for (int i = 0; i < NUM_REGS; i++) begin
            i_host.rd(REG_OFS[i], d, ok);
            chk_bit(ok, 1'b1, "read answer");
            chk_val(13'(d), 13'(REG_RST[i]), "reset value");
        end
        chk_val(13'(flag_v), 13'h0000, "open window");
        $display("test %s done", name);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        error_cnt++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        do_reset();
        chk_reset("reset values");
        for (int i = 0; i < 8; i++) begin
            r = ROWS[i];
            i_host.wr(r.addr, r.lim);
            fast_smp <= r.addr[1] ? 8'h80 : r.smp;
            slow_smp <= r.addr[1] ? r.smp : 8'h80;
            scale <= r.scl;
            repeat (3) @(posedge clk_i);
            #1;
            chk_bit(flag_v[r.addr[1:0]], r.flag, "limit compare");
            chk_val(mv_v[r.addr[1:0]], exp_mv(r.scl, r.lim), "limit mv");
            i_host.rd(r.addr, d, ok);
            chk_val(13'(d), 13'(r.lim), "limit readback");
        end
        $display("test limits done");
        last = CUT_1KHZ;
        for (int c = 0; c < 8; c++) begin
            i_host.wr(OFS_SLOW_CUTOFF, 8'he0 | 8'(c));
            if (c inside {[2:6]}) last = 3'(c);
            repeat (3) @(posedge clk_i);
            #1;
            chk_bit(err, !(c inside {[2:6]}), "cutoff error flag");
            chk_val(13'(cut), 13'(last), "applied cutoff");
            chk_val(hz, HZ_250 << (last - 3'h2), "cutoff hz");
            i_host.rd(OFS_SLOW_CUTOFF, d, ok);
            chk_val(13'(d), 13'(c), "cutoff readback");
        end
        $display("test cutoff done");
        // Under code 3 stays inside the supported span; over code 11 lies beyond it and saturates
        i_host.wr(OFS_FAST_DEBOUNCE, 8'hb3);
        uv_raw <= 1'b1;
        meas(1'b0, 1'b1);
        chk_val(13'(n), 13'(BASE_NS * 8 / CLK_PERIOD_NS), "under settle");
        @(posedge clk_i);
        uv_raw <= 1'b0;
        repeat (7) @(posedge clk_i);
        uv_raw <= 1'b1;
        @(posedge clk_i);
        uv_raw <= 1'b0;
        meas(1'b0, 1'b0);
        chk_val(13'(n), 13'(BASE_NS * 8 / CLK_PERIOD_NS), "bounce restart");
        @(posedge clk_i);
        ov_raw <= 1'b1;
        meas(1'b1, 1'b1);
        chk_val(13'(n), 13'(BASE_NS * 1024 / CLK_PERIOD_NS), "over settle cap");
        $display("test settle done");
        for (int u = 0; u < 2; u++) begin
            if (u == 1) begin
                @(posedge clk_i);
                uv_raw <= 1'b1;
                meas(1'b0, 1'b1);
            end
            for (int k = 0; k < 4; k++) begin
                i_host.wr(OFS_SLOW_CUTOFF, 8'(k * 8 + 4));
                repeat (3) @(posedge clk_i);
                #1;
                chk_bit(rst_req, k[1] | (k[0] & u[0]), "reset routing");
            end
        end
        $display("test routing done");
        do_reset();
        chk_reset("second reset");
        end_of_test();
    end
endmodule
